// ### hdl/sct_pkg.sv
// Function
// - Asleep: oscillator off, registers and port kept.
// - Timed sleep and immediate sleep both supported.
// - Source select 10 picks internal oscillator.
// - Source select 01 picks external crystal.
// - Enable bit 0 runs oscillators, 1 stops.
// - Selected slow clock divided by five-bit divisor.
// - Count fast cycles over sixteen slow periods.
// - Host selects source, then starts calibration.
// - Calibration done flag set on completion.
// - Result split: status nibble plus two bytes.
// - Main counter 26 bits on slow clock.
// - Remain counter 16 bits on fast clock.
// - Wake time match restarts main oscillator.
// - Wake counter withholds fast clock while stabilising.
// - Main plus remain counters time the interval.
// - Alert, gate oscillator on acknowledge, wake on match.
package sct_pkg;

  // ----------------------------------------------------------------
  // Clock rates and derived enables
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ   = 50_000_000;
  localparam int unsigned FAST_OSC_HZ   = 20_000_000;
  localparam logic [5:0]  FAST_ACC_STEP = 6'(FAST_OSC_HZ / 1_000_000);
  localparam logic [5:0]  FAST_ACC_WRAP = 6'(CORE_CLK_HZ / 1_000_000);
  localparam logic [4:0]  CAL_LAST_PERIOD = 5'h0F;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [9:0] ADDR_ACK_WAKE_LO   = 10'h035;
  localparam logic [9:0] ADDR_RFCTL_WAKE_HI = 10'h036;
  localparam logic [9:0] ADDR_SRC_SELECT    = 10'h207;
  localparam logic [9:0] ADDR_CAL_LOW       = 10'h209;
  localparam logic [9:0] ADDR_CAL_MID       = 10'h20A;
  localparam logic [9:0] ADDR_CAL_CTRL      = 10'h20B;
  localparam logic [9:0] ADDR_ENABLE_CTRL   = 10'h211;
  localparam logic [9:0] ADDR_DIVIDER_CTRL  = 10'h220;
  localparam logic [9:0] ADDR_WAKE_TIME_LO  = 10'h222;
  localparam logic [9:0] ADDR_WAKE_TIME_HI  = 10'h223;
  localparam logic [9:0] ADDR_REMAIN_LO     = 10'h224;
  localparam logic [9:0] ADDR_REMAIN_HI     = 10'h225;
  localparam logic [9:0] ADDR_MAIN_B0       = 10'h226;
  localparam logic [9:0] ADDR_MAIN_B1       = 10'h227;
  localparam logic [9:0] ADDR_MAIN_B2       = 10'h228;
  localparam logic [9:0] ADDR_MAIN_B3       = 10'h229;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_ACK        = 7;
  localparam int unsigned BIT_START_CNT  = 7;
  localparam int unsigned BIT_CAL_DONE   = 7;
  localparam int unsigned BIT_CAL_START  = 4;
  localparam int unsigned BIT_OSC_DIS    = 0;
  localparam logic [1:0]  SRC_INTERNAL   = 2'h2;
  localparam logic [1:0]  SRC_EXTERNAL   = 2'h1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  RST_SRC_SELECT = 2'h0;
  localparam logic        RST_OSC_DIS    = 1'b0;
  localparam logic [4:0]  RST_DIVISOR    = 5'h00;
  localparam logic [10:0] RST_WAKE_TIME  = 11'h000;
  localparam logic [8:0]  RST_WAKE_COUNT = 9'h000;
  localparam logic [15:0] RST_REMAIN     = 16'h0000;
  localparam logic [25:0] RST_MAIN       = 26'h0000000;

  // ----------------------------------------------------------------
  // Power sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_AWAKE     = 3'b000,
    ST_ALERT     = 3'b001,
    ST_SLEEP     = 3'b010,
    ST_STABILISE = 3'b011,
    ST_FINISH    = 3'b100
  } sct_state_t;

endpackage

// ### hdl/sct_pin_sync.sv
`timescale 1ns/1ns
module sct_pin_sync (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output logic      o_rise
);

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic level;
    logic rise;
  } sct_sync_t;

  sct_sync_t q;
  sct_sync_t d;

  // ----------------------------------------------------------------
  // Three-stage capture with agreement filter
  // ----------------------------------------------------------------
  // The first stage only feeds the second, so a metastable sample has a
  // full cycle to settle before anything decides on it.
  always_comb begin
    d      = q;
    d.ff1  = i_pin;
    d.ff2  = q.ff1;
    d.ff3  = q.ff2;
    d.rise = 1'b0;
    if ((q.ff2 == q.ff3) && (q.ff3 != q.level)) begin
      d.level = q.ff3;
      d.rise  = q.ff3;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_rise = q.rise;

endmodule

// ### hdl/sct_sleep_timer.sv
`timescale 1ns/1ns
module sct_sleep_timer
  import sct_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_int_osc,
  input  wire logic       i_ext_osc,
  input  wire logic       i_imm_wake,
  input  wire logic [9:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  output logic            o_main_osc_en,
  output logic            o_fast_clk_en,
  output logic            o_slow_tick,
  output logic            o_sleep_alert,
  output logic            o_wake_alert,
  output logic            o_interval_done,
  output logic            o_sleep_active
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sct_state_t  state;
    logic        imm_mode;
    logic [5:0]  fast_acc;
    logic [4:0]  div_cnt;
    logic [1:0]  src_sel;
    logic        osc_dis;
    logic [4:0]  divisor;
    logic [10:0] wake_time;
    logic [8:0]  wake_count;
    logic [15:0] remain_cnt;
    logic [25:0] main_cnt;
    logic [25:0] main_elapsed;
    logic [15:0] remain_elapsed;
    logic [8:0]  wake_elapsed;
    logic [19:0] cal_count;
    logic [4:0]  cal_periods;
    logic        cal_busy;
    logic        cal_armed;
    logic        cal_done;
    logic        sleep_alert;
    logic        wake_alert;
    logic        interval_done;
    logic        slow_tick;
    logic [7:0]  rd_data;
  } sct_core_t;

  sct_core_t q;
  sct_core_t d;

  logic int_rise;
  logic ext_rise;

  // ----------------------------------------------------------------
  // Oscillator pin synchronisers
  // ----------------------------------------------------------------
  sct_pin_sync u_int_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_pin      (i_int_osc),
    .o_rise     (int_rise)
  );

  sct_pin_sync u_ext_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_pin      (i_ext_osc),
    .o_rise     (ext_rise)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [5:0] acc_sum;
    logic [4:0] ratio;
    logic       osc_on;
    logic       fast_tick;
    logic       src_tick;
    logic       slow_tick;
    logic       start_req;
    logic       ack_req;
    logic       cal_req;
    acc_sum   = 6'h00;
    ratio     = 5'h00;
    osc_on    = 1'b0;
    fast_tick = 1'b0;
    src_tick  = 1'b0;
    slow_tick = 1'b0;
    start_req = 1'b0;
    ack_req   = 1'b0;
    cal_req   = 1'b0;

    d               = q;
    d.rd_data       = 8'h00;
    d.wake_alert    = 1'b0;
    d.interval_done = 1'b0;

    // ----------------------------------------------------------------
    // Fast oscillator stand-in: 20 ticks per 50 core cycles, stopped asleep.
    // ----------------------------------------------------------------
    osc_on = (q.state != ST_SLEEP);
    if (osc_on) begin
      acc_sum = q.fast_acc + FAST_ACC_STEP;
      if (acc_sum >= FAST_ACC_WRAP) begin
        d.fast_acc = acc_sum - FAST_ACC_WRAP;
        fast_tick  = 1'b1;
      end else begin
        d.fast_acc = acc_sum;
      end
    end else begin
      d.fast_acc = 6'h00;
    end

    // ----------------------------------------------------------------
    // Slow source selection and stop control.
    // ----------------------------------------------------------------
    // A stopped or unselected source gives no ticks, so the divider holds.
    if (!q.osc_dis) begin
      if (q.src_sel == SRC_INTERNAL) begin
        src_tick = int_rise;
      end else if (q.src_sel == SRC_EXTERNAL) begin
        src_tick = ext_rise;
      end
    end

    // ----------------------------------------------------------------
    // Divisor values 0 and 1 both pass the source through undivided.
    // ----------------------------------------------------------------
    ratio = (q.divisor == 5'h00) ? 5'h01 : q.divisor;
    if (src_tick) begin
      if ((q.div_cnt + 5'h01) >= ratio) begin
        d.div_cnt = 5'h00;
        slow_tick = 1'b1;
      end else begin
        d.div_cnt = q.div_cnt + 5'h01;
      end
    end
    d.slow_tick = slow_tick;

    // ----------------------------------------------------------------
    // Register port strobes.
    // ----------------------------------------------------------------
    if (i_reg_wr) begin
      start_req = (i_reg_addr == ADDR_MAIN_B3) && i_reg_wdata[BIT_START_CNT];
      ack_req   = (i_reg_addr == ADDR_ACK_WAKE_LO) && i_reg_wdata[BIT_ACK];
      cal_req   = (i_reg_addr == ADDR_CAL_CTRL) && i_reg_wdata[BIT_CAL_START];
    end

    // ----------------------------------------------------------------
    // Calibration: wait for a slow edge, then count over sixteen periods.
    // ----------------------------------------------------------------
    if (q.cal_busy) begin
      if (!q.cal_armed) begin
        if (slow_tick) begin
          d.cal_armed = 1'b1;
        end
      end else begin
        if (fast_tick) begin
          d.cal_count = q.cal_count + 20'h00001;
        end
        if (slow_tick) begin
          d.cal_periods = q.cal_periods + 5'h01;
          if (q.cal_periods == CAL_LAST_PERIOD) begin
            d.cal_busy = 1'b0;
            d.cal_done = 1'b1;
          end
        end
      end
    end

    // A fresh start wins over a completion landing in the same cycle.
    if (cal_req) begin
      d.cal_count   = 20'h00000;
      d.cal_done    = 1'b0;
      d.cal_periods = 5'h00;
      d.cal_busy    = 1'b1;
      d.cal_armed   = 1'b0;
    end

    // ----------------------------------------------------------------
    // Power sequencer.
    // ----------------------------------------------------------------
    // Acknowledge while awake is immediate sleep; during the alert it is timed.
    case (q.state)
      ST_AWAKE: begin
        if (ack_req) begin
          d.state    = ST_SLEEP;
          d.imm_mode = 1'b1;
        end else if (start_req) begin
          d.state          = ST_ALERT;
          d.imm_mode       = 1'b0;
          d.sleep_alert    = 1'b1;
          d.main_elapsed   = 26'h0000000;
          d.remain_elapsed = 16'h0000;
        end
      end
      ST_ALERT: begin
        if (slow_tick) begin
          d.main_elapsed = q.main_elapsed + 26'h0000001;
        end
        if (ack_req) begin
          d.state       = ST_SLEEP;
          d.sleep_alert = 1'b0;
        end
      end
      ST_SLEEP: begin
        if (q.imm_mode) begin
          if (i_imm_wake) begin
            d.state        = ST_STABILISE;
            d.wake_elapsed = 9'h000;
          end
        end else begin
          if (slow_tick) begin
            d.main_elapsed = q.main_elapsed + 26'h0000001;
          end
          // A wake time already passed is met again only after the count wraps.
          if (q.main_elapsed == {15'h0000, q.wake_time}) begin
            d.state        = ST_STABILISE;
            d.wake_elapsed = 9'h000;
          end
        end
      end
      ST_STABILISE: begin
        if (slow_tick && !q.imm_mode) begin
          d.main_elapsed = q.main_elapsed + 26'h0000001;
        end
        if (q.wake_elapsed >= q.wake_count) begin
          d.wake_alert = 1'b1;
          d.state      = q.imm_mode ? ST_AWAKE : ST_FINISH;
        end else if (slow_tick) begin
          d.wake_elapsed = q.wake_elapsed + 9'h001;
        end
      end
      ST_FINISH: begin
        if (q.main_elapsed < q.main_cnt) begin
          if (slow_tick) begin
            d.main_elapsed = q.main_elapsed + 26'h0000001;
          end
        end else if (q.remain_elapsed < q.remain_cnt) begin
          if (fast_tick) begin
            d.remain_elapsed = q.remain_elapsed + 16'h0001;
          end
        end else begin
          d.interval_done = 1'b1;
          d.state         = ST_AWAKE;
        end
      end
      default: begin
        d.state = ST_AWAKE;
      end
    endcase

    // ----------------------------------------------------------------
    // Register writes; the port stays live in every state.
    // ----------------------------------------------------------------
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_ACK_WAKE_LO:   d.wake_count[6:0]  = i_reg_wdata[6:0];
        ADDR_RFCTL_WAKE_HI: d.wake_count[8:7]  = i_reg_wdata[4:3];
        ADDR_SRC_SELECT:    d.src_sel          = i_reg_wdata[7:6];
        ADDR_ENABLE_CTRL:   d.osc_dis          = i_reg_wdata[BIT_OSC_DIS];
        ADDR_DIVIDER_CTRL:  d.divisor          = i_reg_wdata[4:0];
        ADDR_WAKE_TIME_LO:  d.wake_time[7:0]   = i_reg_wdata;
        ADDR_WAKE_TIME_HI:  d.wake_time[10:8]  = i_reg_wdata[2:0];
        ADDR_REMAIN_LO:     d.remain_cnt[7:0]  = i_reg_wdata;
        ADDR_REMAIN_HI:     d.remain_cnt[15:8] = i_reg_wdata;
        ADDR_MAIN_B0:       d.main_cnt[7:0]    = i_reg_wdata;
        ADDR_MAIN_B1:       d.main_cnt[15:8]   = i_reg_wdata;
        ADDR_MAIN_B2:       d.main_cnt[23:16]  = i_reg_wdata;
        ADDR_MAIN_B3:       d.main_cnt[25:24]  = i_reg_wdata[1:0];
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Registered read answer; self-clearing and reserved bits read zero.
    // ----------------------------------------------------------------
    if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_ACK_WAKE_LO:   d.rd_data = {1'b0, q.wake_count[6:0]};
        ADDR_RFCTL_WAKE_HI: d.rd_data = {3'h0, q.wake_count[8:7], 3'h0};
        ADDR_SRC_SELECT:    d.rd_data = {q.src_sel, 6'h00};
        ADDR_CAL_LOW:       d.rd_data = q.cal_count[7:0];
        ADDR_CAL_MID:       d.rd_data = q.cal_count[15:8];
        ADDR_CAL_CTRL:      d.rd_data = {q.cal_done, 3'h0, q.cal_count[19:16]};
        ADDR_ENABLE_CTRL:   d.rd_data = {7'h00, q.osc_dis};
        ADDR_DIVIDER_CTRL:  d.rd_data = {3'h0, q.divisor};
        ADDR_WAKE_TIME_LO:  d.rd_data = q.wake_time[7:0];
        ADDR_WAKE_TIME_HI:  d.rd_data = {5'h00, q.wake_time[10:8]};
        ADDR_REMAIN_LO:     d.rd_data = q.remain_cnt[7:0];
        ADDR_REMAIN_HI:     d.rd_data = q.remain_cnt[15:8];
        ADDR_MAIN_B0:       d.rd_data = q.main_cnt[7:0];
        ADDR_MAIN_B1:       d.rd_data = q.main_cnt[15:8];
        ADDR_MAIN_B2:       d.rd_data = q.main_cnt[23:16];
        ADDR_MAIN_B3:       d.rd_data = {6'h00, q.main_cnt[25:24]};
        default:            d.rd_data = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset leaves the sequencer awake with the oscillator running, so the port answers at once.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q            <= '0;
      q.state      <= ST_AWAKE;
      q.src_sel    <= RST_SRC_SELECT;
      q.osc_dis    <= RST_OSC_DIS;
      q.divisor    <= RST_DIVISOR;
      q.wake_time  <= RST_WAKE_TIME;
      q.wake_count <= RST_WAKE_COUNT;
      q.remain_cnt <= RST_REMAIN;
      q.main_cnt   <= RST_MAIN;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The radio clock is withheld both asleep and while the oscillator settles.
  assign o_main_osc_en   = (q.state != ST_SLEEP);
  assign o_fast_clk_en   = (q.state != ST_SLEEP) && (q.state != ST_STABILISE);
  assign o_slow_tick     = q.slow_tick;
  assign o_sleep_alert   = q.sleep_alert;
  assign o_wake_alert    = q.wake_alert;
  assign o_interval_done = q.interval_done;
  assign o_sleep_active  = (q.state == ST_SLEEP) || (q.state == ST_STABILISE);
  assign o_reg_rdata     = q.rd_data;

endmodule

// ### tb/sct_sleep_timer_chk.sv
`timescale 1ns/1ns
module sct_sleep_timer_chk
  import sct_pkg::*;
(
  input wire logic       i_core_clk,
  input wire logic       i_rst_n,
  input wire logic       i_int_osc,
  input wire logic       i_ext_osc,
  input wire logic       i_imm_wake,
  input wire logic [9:0] i_reg_addr,
  input wire logic       i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_main_osc_en,
  input wire logic       o_fast_clk_en,
  input wire logic       o_slow_tick,
  input wire logic       o_sleep_alert,
  input wire logic       o_wake_alert,
  input wire logic       o_interval_done,
  input wire logic       o_sleep_active
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------------------------------
  // Decoded writes
  // ----------------------------------------------------------------
  logic ack_wr;
  logic start_wr;
  logic cal_wr;
  assign ack_wr   = i_reg_wr && i_reg_addr == ADDR_ACK_WAKE_LO && i_reg_wdata[BIT_ACK];
  assign start_wr = i_reg_wr && i_reg_addr == ADDR_MAIN_B3 && i_reg_wdata[BIT_START_CNT];
  assign cal_wr   = i_reg_wr && i_reg_addr == ADDR_CAL_CTRL && i_reg_wdata[BIT_CAL_START];
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_rd_idle; !$past(i_reg_rd) |-> o_reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_gate; !o_main_osc_en |-> !o_fast_clk_en && o_sleep_active; endproperty
  a_gate: assert property (p_gate) else $error("clock released while asleep");
  property p_ack; ack_wr && !o_sleep_active |=> !o_main_osc_en && !o_sleep_alert; endproperty
  a_ack: assert property (p_ack) else $error("acknowledge did not sleep");
  property p_start; start_wr && !o_sleep_active && !o_sleep_alert |=> o_sleep_alert; endproperty
  a_start: assert property (p_start) else $error("start gave no alert");
  property p_restart; $rose(o_main_osc_en) |-> !o_fast_clk_en; endproperty
  a_restart: assert property (p_restart) else $error("clock not withheld");
  property p_walert; o_wake_alert |=> !o_wake_alert && o_fast_clk_en; endproperty
  a_walert: assert property (p_walert) else $error("wake alert wrong");
  property p_tick; o_slow_tick |=> !o_slow_tick; endproperty
  a_tick: assert property (p_tick) else $error("slow tick too long");
  property p_cal_clr;
    cal_wr ##[1:2] (i_reg_rd && i_reg_addr == ADDR_CAL_CTRL) |=> !o_reg_rdata[BIT_CAL_DONE];
  endproperty
  a_cal_clr: assert property (p_cal_clr) else $error("stale done flag");
  property p_done; o_interval_done |-> o_main_osc_en && o_fast_clk_en && !o_sleep_active; endproperty
  a_done: assert property (p_done) else $error("interval end while asleep");
endmodule

bind sct_sleep_timer sct_sleep_timer_chk i_sct_sleep_timer_chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_int_osc(i_int_osc),
  .i_ext_osc(i_ext_osc), .i_imm_wake(i_imm_wake), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_main_osc_en(o_main_osc_en),
  .o_fast_clk_en(o_fast_clk_en), .o_slow_tick(o_slow_tick),
  .o_sleep_alert(o_sleep_alert), .o_wake_alert(o_wake_alert),
  .o_interval_done(o_interval_done), .o_sleep_active(o_sleep_active)
);

// ### tb/sct_osc_model.sv
`timescale 1ns/1ns
module sct_osc_model #(
  parameter int INT_HALF_NS = 5000,
  parameter int EXT_HALF_NS = 15259
) (
  input  wire logic i_run,
  output logic      o_int_osc,
  output logic      o_ext_osc
);
  // Sources stand still low until i_run, so no edge leaks out during reset.
  logic int_q = 1'b0;
  logic ext_q = 1'b0;
  always #(INT_HALF_NS) int_q = i_run & ~int_q;
  always #(EXT_HALF_NS) ext_q = i_run & ~ext_q;
  assign o_int_osc = int_q;
  assign o_ext_osc = ext_q;
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import sct_pkg::*;
  typedef struct {
    string       nm;
    logic [31:0] ex;
    int          tol;
  } sct_note_t;
  logic       clk   = 1'b0;
  logic       rst_n = 1'b0;
  logic       imm   = 1'b0;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic       chk   = 1'b0;
  logic       chk_q = 1'b0;
  logic       run   = 1'b0;
  logic [9:0] addr  = 10'h000;
  logic [7:0] wd    = 8'h00;
  logic [7:0] lf    = 8'h3C;
  logic [7:0] rdata;
  logic       osc_en, fclk, tick, alert, walert, idone, sact, int_osc, ext_osc;
  int         n_mismatch = 0;
  int         n_checks   = 0;
  int         cyc        = 0;
  sct_note_t  q[$];
  localparam logic [9:0] AD [17] = '{ADDR_ACK_WAKE_LO, ADDR_RFCTL_WAKE_HI, ADDR_SRC_SELECT,
    ADDR_CAL_LOW, ADDR_CAL_MID, ADDR_CAL_CTRL, ADDR_ENABLE_CTRL, ADDR_DIVIDER_CTRL,
    ADDR_WAKE_TIME_LO, ADDR_WAKE_TIME_HI, ADDR_REMAIN_LO, ADDR_REMAIN_HI, ADDR_MAIN_B0,
    ADDR_MAIN_B1, ADDR_MAIN_B2, ADDR_MAIN_B3, 10'h100};
  localparam logic [7:0] RM [17] = '{8'h7F, 8'h18, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h01, 8'h1F,
    8'hFF, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'h00};

  initial forever #10 clk = ~clk;

  sct_osc_model i_sct_osc_model (.i_run(run), .o_int_osc(int_osc), .o_ext_osc(ext_osc));
  sct_sleep_timer i_sct_sleep_timer (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_int_osc(int_osc), .i_ext_osc(ext_osc),
    .i_imm_wake(imm), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wd), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_main_osc_en(osc_en), .o_fast_clk_en(fclk), .o_slow_tick(tick),
    .o_sleep_alert(alert), .o_wake_alert(walert), .o_interval_done(idone),
    .o_sleep_active(sact));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic logic sig(input int k);
    case (k)
      0: return osc_en;
      1: return walert;
      2: return idone;
      default: return tick;
    endcase
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] sn,
                     input int tol);
    n_checks++;
    if (!(sn === ex || (!$isunknown(sn) && sn + tol >= ex && sn <= ex + tol))) begin
      $display("mismatch %s expected %0d seen %0d", nm, ex, sn);
      n_mismatch++;
    end
  endtask
  task automatic wreg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [9:0] a, input string nm, input logic [7:0] ex, input int tol);
    q.push_back('{nm, 32'(ex), tol});
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    chk <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    chk <= 1'b0;
  endtask
  task automatic peek(input logic [9:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic wait_hi(input int k, input int lim, output int c);
    c = 0;
    while (sig(k) !== 1'b1 && c < lim) begin
      @(negedge clk);
      c++;
    end
  endtask
  task automatic span(output int c);
    wait_hi(3, 4000, c);
    @(negedge clk);
    wait_hi(3, 4000, c);
    c++;
  endtask

  // Read results are judged one cycle after the read edge, oldest note first.
  always @(posedge clk) chk_q <= rd & chk;
  always @(negedge clk) begin
    sct_note_t n;
    if (chk_q && q.size() > 0) begin
      n = q.pop_front();
      cmp(n.nm, n.ex, 32'(rdata), n.tol);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v;
    int         c;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    run <= 1'b1;
    for (int i = 0; i < 17; i++) rreg(AD[i], "reset", 8'h00, 0);
    $display("test reset done");
    for (int i = 0; i < 17; i++) begin
      wreg(AD[i], (i == 0 || i == 15) ? lf & 8'h7F : lf);
      rreg(AD[i], "rw", lf & RM[i], 0);
      lf = lfsr(lf);
    end
    $display("test access done");
    wreg(ADDR_ENABLE_CTRL, 8'h00);
    wreg(ADDR_SRC_SELECT, 8'h80);
    wreg(ADDR_DIVIDER_CTRL, 8'h01);
    span(c);
    cmp("internal tick", 500, c, 3);
    wreg(ADDR_DIVIDER_CTRL, 8'h03);
    span(c);
    cmp("divided tick", 1500, c, 3);
    wreg(ADDR_SRC_SELECT, 8'h40);
    wreg(ADDR_DIVIDER_CTRL, 8'h00);
    span(c);
    span(c);
    cmp("external tick", 1526, c, 3);
    wreg(ADDR_ENABLE_CTRL, 8'h01);
    repeat (2) @(negedge clk);
    wait_hi(3, 1800, c);
    cmp("stopped osc", 1800, c, 0);
    wreg(ADDR_ENABLE_CTRL, 8'h00);
    wreg(ADDR_SRC_SELECT, 8'h00);
    repeat (2) @(negedge clk);
    wait_hi(3, 1800, c);
    cmp("no source", 1800, c, 0);
    $display("test slow clock done");
    wreg(ADDR_SRC_SELECT, 8'h80);
    wreg(ADDR_DIVIDER_CTRL, 8'h01);
    wreg(ADDR_CAL_CTRL, 8'h10);
    rreg(ADDR_CAL_CTRL, "cal cleared", 8'h00, 0);
    v = 8'h00;
    for (int i = 0; i < 6000 && v[7] !== 1'b1; i++) peek(ADDR_CAL_CTRL, v);
    cmp("cal done", 1, 32'(v[7]), 0);
    // Sixteen 10 us periods at 50 ns per count give 3200, 0xC80.
    rreg(ADDR_CAL_LOW, "cal low", 8'h80, 3);
    rreg(ADDR_CAL_MID, "cal mid", 8'h0C, 0);
    rreg(ADDR_CAL_CTRL, "cal status", 8'h80, 0);
    $display("test calibration done");
    wreg(ADDR_WAKE_TIME_LO, 8'h02);
    wreg(ADDR_WAKE_TIME_HI, 8'h00);
    wreg(ADDR_RFCTL_WAKE_HI, 8'h00);
    wreg(ADDR_REMAIN_LO, 8'h0A);
    wreg(ADDR_REMAIN_HI, 8'h00);
    wreg(ADDR_MAIN_B0, 8'h04);
    wreg(ADDR_MAIN_B1, 8'h00);
    wreg(ADDR_MAIN_B2, 8'h00);
    wreg(ADDR_MAIN_B3, 8'h80);
    @(negedge clk);
    cmp("alert", 1, 32'(alert), 0);
    wreg(ADDR_ACK_WAKE_LO, 8'h81);
    @(negedge clk);
    cmp("osc off", 0, 32'(osc_en), 0);
    cmp("alert cleared", 0, 32'(alert), 0);
    cmp("asleep", 1, 32'(sact), 0);
    rreg(ADDR_MAIN_B0, "port asleep", 8'h04, 0);
    wait_hi(0, 1500, c);
    cmp("osc restart", 1, 32'(osc_en), 0);
    cmp("clk withheld", 0, 32'(fclk), 0);
    wait_hi(1, 1100, c);
    cmp("wake alert", 1, 32'(walert), 0);
    wait_hi(2, 2500, c);
    cmp("interval", 1, 32'(idone), 0);
    $display("test timed sleep done");
    wreg(ADDR_ACK_WAKE_LO, 8'h80);
    repeat (20) @(posedge clk);
    @(negedge clk);
    cmp("imm asleep", 0, 32'(osc_en), 0);
    @(posedge clk);
    imm <= 1'b1;
    wait_hi(0, 20, c);
    cmp("imm restart", 1, 32'(osc_en), 0);
    wait_hi(1, 600, c);
    cmp("imm wake", 1, 32'(walert), 0);
    @(posedge clk);
    imm <= 1'b0;
    $display("test immediate sleep done");
    final_report();
  end
endmodule
